// ### bwds_defs.vh
`ifndef BWDS_DEFS_VH
`define BWDS_DEFS_VH

// Dword-aligned configuration offsets
`define BWDS_DW_IO_STATUS      8'h1C
`define BWDS_DW_MEM_WINDOW     8'h20
`define BWDS_DW_PREFETCH       8'h24
`define BWDS_DW_PREFETCH_HIGH  8'h28

// Byte offsets of the registers held here
`define BWDS_OFS_IO_TOP        8'h1D
`define BWDS_OFS_SEC_STATUS    8'h1E
`define BWDS_OFS_MEM_BASE      8'h20
`define BWDS_OFS_MEM_TOP       8'h22
`define BWDS_OFS_PF_BASE       8'h24
`define BWDS_OFS_PF_TOP        8'h26
`define BWDS_OFS_PF_BASE_HIGH  8'h28

// Reset values
`define BWDS_RST_IO_TOP        8'h01
`define BWDS_RST_MEM_BASE      16'h0000
`define BWDS_RST_MEM_TOP       16'h0000
`define BWDS_RST_PF_BASE       16'h0001
`define BWDS_RST_PF_TOP        16'h0001
`define BWDS_RST_PF_BASE_HIGH  32'h00000000

// Read-only field values
`define BWDS_IO_ADDRESSING_KIND  4'h1
`define BWDS_WIDE_ADDRESS_IND    4'h1
`define BWDS_DECODE_TIMING       2'h1
`define BWDS_BACK_TO_BACK_CAP    1'b1
`define BWDS_HIGH_CLOCK_CAP      1'b1

// Boundary fill for the low address bits
`define BWDS_IO_LOW_ZERO       12'h000
`define BWDS_IO_LOW_ONES       12'hFFF
`define BWDS_MEM_LOW_ZERO      20'h00000
`define BWDS_MEM_LOW_ONES      20'hFFFFF

// Secondary status event flag positions (bit 8 is the master parity flag)
`define BWDS_STS_PARITY        15
`define BWDS_STS_SYSTEM        14
`define BWDS_STS_MASTER_TERM   13
`define BWDS_STS_TARGET_RECV   12
`define BWDS_STS_TARGET_SIG    11
`define BWDS_STS_MASTER_PAR    8

`endif

// ### bwds_window_cmp.v
`timescale 1ns/1ps
`default_nettype none

// Inclusive window compare: hit when bottom <= addr <= top
module bwds_window_cmp #(
  parameter W = 32
) (
  // Address and boundaries
  input  wire [W-1:0] addr_i,
  input  wire [W-1:0] bottom_i,
  input  wire [W-1:0] top_i,
  // Result
  output wire         hit_o
);

  assign hit_o = (addr_i >= bottom_i) && (addr_i <= top_i);

endmodule

`default_nettype wire

// ### bwds_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "bwds_defs.vh"

// Functional notes
// - I/O top bits 7:4 give address 15:12, FFFh
// - I/O top bits 31:16 from upper register
// - I/O top bits 3:0 read 1h
// - I/O window decides I/O forwarding
// - Bit 15 on three parity conditions
// - Bit 15 ignores parity response enable
// - Bit 14 set on secondary SERR
// - Bit 13 set on master abort
// - Bit 12 set on received target abort
// - Bit 11 set on signaled target abort
// - Bits 10:9 read 01b
// - Bit 8 master, enable, PERR conditions
// - Bit 7 reads one
// - Bit 5 reads one
// - Bits 6 and 4:0 read zero
// - Event flags sticky until cleared
// - Memory base bits 15:4 give 31:20
// - Memory top bits 15:4, low ones
// - Prefetch bottom uses upper base register
// - Prefetch top uses upper top register
// - Prefetch registers bits 3:0 read 1h
// - Upper prefetch base fully writable
// - I/O bottom bits 7:4, low zero
module bwds_regs (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        sys_rst_i,
  // Configuration access, dword address plus byte enables
  input  wire [7:0]  cfg_addr_i,
  input  wire [3:0]  cfg_be_i,
  input  wire        cfg_wr_i,
  input  wire [31:0] cfg_wdata_i,
  input  wire        cfg_rd_i,
  output reg  [31:0] cfg_rdata_o,
  output reg         cfg_rvalid_o,
  // Fields held in neighbouring registers
  input  wire [3:0]  io_bottom_field_i,
  input  wire [15:0] io_bottom_upper_i,
  input  wire [15:0] io_top_upper_i,
  input  wire [31:0] prefetch_top_high_i,
  input  wire        parity_response_enable_i,
  // Secondary bus events, one-cycle pulses
  input  wire        addr_attr_fault_target_i,
  input  wire        write_data_fault_target_i,
  input  wire        read_data_fault_master_i,
  input  wire        serr_seen_i,
  input  wire        master_termination_i,
  input  wire        target_termination_recv_i,
  input  wire        target_termination_sig_i,
  input  wire        bus_master_i,
  input  wire        perr_driven_read_i,
  input  wire        perr_seen_write_i,
  // Forwarding decode
  input  wire [31:0] io_addr_i,
  input  wire [63:0] mem_addr_i,
  output reg         io_forward_o,
  output reg         mem_forward_o,
  output reg         prefetch_forward_o
);

  // Stored fields are the upper bits of each reset value
  localparam [7:0]  RST_IO_TOP   = `BWDS_RST_IO_TOP;
  localparam [15:0] RST_MEM_BASE = `BWDS_RST_MEM_BASE;
  localparam [15:0] RST_MEM_TOP  = `BWDS_RST_MEM_TOP;
  localparam [15:0] RST_PF_BASE  = `BWDS_RST_PF_BASE;
  localparam [15:0] RST_PF_TOP   = `BWDS_RST_PF_TOP;

  // Dword select; the low two address bits are ignored, byte enables pick the bytes
  function dw_hit;
    input [7:0] addr;
    input [7:0] dword_ofs;
    begin
      dw_hit = (addr[7:2] == dword_ofs[7:2]);
    end
  endfunction

  // Byte-lane merge of a write into a stored dword
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  be;
    integer      i;
    begin
      lane_merge = old_val;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
    end
  endfunction

  reg  [3:0]  io_top_field_reg;
  reg  [3:0]  io_top_field_next;
  reg  [11:0] memory_bottom_field_reg;
  reg  [11:0] memory_bottom_field_next;
  reg  [11:0] memory_top_field_reg;
  reg  [11:0] memory_top_field_next;
  reg  [11:0] prefetch_bottom_field_reg;
  reg  [11:0] prefetch_bottom_field_next;
  reg  [11:0] prefetch_top_field_reg;
  reg  [11:0] prefetch_top_field_next;
  reg  [31:0] prefetch_base_high_reg;
  reg  [31:0] prefetch_base_high_next;
  reg  [15:0] status_flags_reg;
  reg  [15:0] status_flags_next;
  reg  [31:0] cfg_rdata_next;

  wire [31:0] dw_io_status;
  wire [31:0] dw_mem_window;
  wire [31:0] dw_prefetch;
  wire [15:0] sec_status;
  wire [15:0] flag_mask;
  wire [15:0] flag_set;
  wire [15:0] flag_clear;
  wire [31:0] io_bottom_addr;
  wire [31:0] io_top_addr;
  wire [31:0] mem_bottom_addr;
  wire [31:0] mem_top_addr;
  wire [63:0] pf_bottom_addr;
  wire [63:0] pf_top_addr;
  wire        io_hit;
  wire        mem_hit;
  wire        pf_hit;
  wire        wr_io_status;
  wire        wr_mem_window;
  wire        wr_prefetch;
  wire        wr_prefetch_high;
  wire        rd_io_status;
  wire        rd_mem_window;
  wire        rd_prefetch;
  wire        rd_prefetch_high;
  wire [31:0] mem_merged;
  wire [31:0] pf_merged;

  // Low two address bits are ignored; configuration is dword based
  assign wr_io_status     = cfg_wr_i &&
                            dw_hit(cfg_addr_i, `BWDS_DW_IO_STATUS);
  assign wr_mem_window    = cfg_wr_i &&
                            dw_hit(cfg_addr_i, `BWDS_DW_MEM_WINDOW);
  assign wr_prefetch      = cfg_wr_i &&
                            dw_hit(cfg_addr_i, `BWDS_DW_PREFETCH);
  assign wr_prefetch_high = cfg_wr_i &&
                            dw_hit(cfg_addr_i, `BWDS_DW_PREFETCH_HIGH);

  // Read selects share the write decode
  assign rd_io_status     = cfg_rd_i &&
                            dw_hit(cfg_addr_i, `BWDS_DW_IO_STATUS);
  assign rd_mem_window    = cfg_rd_i &&
                            dw_hit(cfg_addr_i, `BWDS_DW_MEM_WINDOW);
  assign rd_prefetch      = cfg_rd_i &&
                            dw_hit(cfg_addr_i, `BWDS_DW_PREFETCH);
  assign rd_prefetch_high = cfg_rd_i &&
                            dw_hit(cfg_addr_i, `BWDS_DW_PREFETCH_HIGH);

  // Byte lanes of a write merged over the current dword contents
  assign mem_merged = lane_merge(dw_mem_window, cfg_wdata_i, cfg_be_i);
  assign pf_merged  = lane_merge(dw_prefetch, cfg_wdata_i, cfg_be_i);

  // Only the event positions are storage; everything else is constant
  assign flag_mask = (16'h1 << `BWDS_STS_PARITY)
                   | (16'h1 << `BWDS_STS_SYSTEM)
                   | (16'h1 << `BWDS_STS_MASTER_TERM)
                   | (16'h1 << `BWDS_STS_TARGET_RECV)
                   | (16'h1 << `BWDS_STS_TARGET_SIG)
                   | (16'h1 << `BWDS_STS_MASTER_PAR);

  // Parity flag deliberately ignores the response enable
  assign flag_set[`BWDS_STS_PARITY] = addr_attr_fault_target_i
                                    | write_data_fault_target_i
                                    | read_data_fault_master_i;
  assign flag_set[`BWDS_STS_SYSTEM]      = serr_seen_i;
  assign flag_set[`BWDS_STS_MASTER_TERM] = master_termination_i;
  assign flag_set[`BWDS_STS_TARGET_RECV] = target_termination_recv_i;
  assign flag_set[`BWDS_STS_TARGET_SIG]  = target_termination_sig_i;
  assign flag_set[10:9] = 2'h0;
  assign flag_set[`BWDS_STS_MASTER_PAR] = bus_master_i
                                        & parity_response_enable_i
                                        & (perr_driven_read_i
                                           | perr_seen_write_i);
  assign flag_set[7:0] = 8'h00;

  // Status occupies the upper half of the dword
  assign flag_clear = wr_io_status ?
                      (cfg_wdata_i[31:16]
                       & {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}}
                       & flag_mask) : 16'h0000;

  assign sec_status = (status_flags_reg & flag_mask)
                    | {5'h00, `BWDS_DECODE_TIMING, 1'b0,
                       `BWDS_BACK_TO_BACK_CAP, 1'b0,
                       `BWDS_HIGH_CLOCK_CAP, 5'h00};

  assign dw_io_status  = {sec_status,
                          io_top_field_reg, `BWDS_IO_ADDRESSING_KIND,
                          io_bottom_field_i,
                          `BWDS_IO_ADDRESSING_KIND};
  assign dw_mem_window = {memory_top_field_reg, 4'h0,
                          memory_bottom_field_reg, 4'h0};
  assign dw_prefetch   = {prefetch_top_field_reg, `BWDS_WIDE_ADDRESS_IND,
                          prefetch_bottom_field_reg,
                          `BWDS_WIDE_ADDRESS_IND};

  always @*
  begin
    io_top_field_next         = io_top_field_reg;
    memory_bottom_field_next  = memory_bottom_field_reg;
    memory_top_field_next     = memory_top_field_reg;
    prefetch_bottom_field_next = prefetch_bottom_field_reg;
    prefetch_top_field_next   = prefetch_top_field_reg;
    prefetch_base_high_next   = prefetch_base_high_reg;
    // Set wins over a clear in the same cycle
    status_flags_next = ((status_flags_reg & ~flag_clear) | flag_set)
                        & flag_mask;
    if (wr_io_status && cfg_be_i[1])
      io_top_field_next = cfg_wdata_i[15:12];
    if (wr_mem_window)
    begin
      memory_bottom_field_next = mem_merged[15:4];
      memory_top_field_next    = mem_merged[31:20];
    end
    if (wr_prefetch)
    begin
      prefetch_bottom_field_next = pf_merged[15:4];
      prefetch_top_field_next    = pf_merged[31:20];
    end
    if (wr_prefetch_high)
      prefetch_base_high_next = lane_merge(prefetch_base_high_reg,
                                           cfg_wdata_i, cfg_be_i);
  end

  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      io_top_field_reg          <= RST_IO_TOP[7:4];
      memory_bottom_field_reg   <= RST_MEM_BASE[15:4];
      memory_top_field_reg      <= RST_MEM_TOP[15:4];
      prefetch_bottom_field_reg <= RST_PF_BASE[15:4];
      prefetch_top_field_reg    <= RST_PF_TOP[15:4];
      prefetch_base_high_reg    <= `BWDS_RST_PF_BASE_HIGH;
      status_flags_reg          <= 16'h0000;
    end
    else
    begin
      io_top_field_reg          <= io_top_field_next;
      memory_bottom_field_reg   <= memory_bottom_field_next;
      memory_top_field_reg      <= memory_top_field_next;
      prefetch_bottom_field_reg <= prefetch_bottom_field_next;
      prefetch_top_field_reg    <= prefetch_top_field_next;
      prefetch_base_high_reg    <= prefetch_base_high_next;
      status_flags_reg          <= status_flags_next;
    end
  end

  // Unmapped dwords read zero; without a read the last value stays
  always @*
  begin
    cfg_rdata_next = cfg_rdata_o;
    if (rd_io_status)
      cfg_rdata_next = dw_io_status;
    else if (rd_mem_window)
      cfg_rdata_next = dw_mem_window;
    else if (rd_prefetch)
      cfg_rdata_next = dw_prefetch;
    else if (rd_prefetch_high)
      cfg_rdata_next = prefetch_base_high_reg;
    else if (cfg_rd_i)
      cfg_rdata_next = 32'h00000000;
  end

  // Read data is registered so the output comes from a flip-flop
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      cfg_rdata_o  <= 32'h00000000;
      cfg_rvalid_o <= 1'b0;
    end
    else
    begin
      cfg_rdata_o  <= cfg_rdata_next;
      cfg_rvalid_o <= cfg_rd_i;
    end
  end

  // Window boundaries
  assign io_bottom_addr  = {io_bottom_upper_i, io_bottom_field_i,
                            `BWDS_IO_LOW_ZERO};
  assign io_top_addr     = {io_top_upper_i, io_top_field_reg,
                            `BWDS_IO_LOW_ONES};
  assign mem_bottom_addr = {memory_bottom_field_reg,
                            `BWDS_MEM_LOW_ZERO};
  assign mem_top_addr    = {memory_top_field_reg,
                            `BWDS_MEM_LOW_ONES};
  assign pf_bottom_addr  = {prefetch_base_high_reg, prefetch_bottom_field_reg,
                            `BWDS_MEM_LOW_ZERO};
  assign pf_top_addr     = {prefetch_top_high_i, prefetch_top_field_reg,
                            `BWDS_MEM_LOW_ONES};

  bwds_window_cmp #(.W(32)) u_io_cmp (
    .addr_i   (io_addr_i),
    .bottom_i (io_bottom_addr),
    .top_i    (io_top_addr),
    .hit_o    (io_hit)
  );

  bwds_window_cmp #(.W(32)) u_mem_cmp (
    .addr_i   (mem_addr_i[31:0]),
    .bottom_i (mem_bottom_addr),
    .top_i    (mem_top_addr),
    .hit_o    (mem_hit)
  );

  bwds_window_cmp #(.W(64)) u_pf_cmp (
    .addr_i   (mem_addr_i),
    .bottom_i (pf_bottom_addr),
    .top_i    (pf_top_addr),
    .hit_o    (pf_hit)
  );

  // The plain memory window only reaches the low 4 GB
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      io_forward_o       <= 1'b0;
      mem_forward_o      <= 1'b0;
      prefetch_forward_o <= 1'b0;
    end
    else
    begin
      io_forward_o       <= io_hit;
      mem_forward_o      <= mem_hit && (mem_addr_i[63:32] == 32'h0);
      prefetch_forward_o <= pf_hit;
    end
  end

endmodule

`default_nettype wire

// ### bwds_pci_model.sv
`timescale 1ns/1ps
`default_nettype none
// Secondary bus agent: each request bit is registered into an event pulse one cycle later
module bwds_pci_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  // Event requests and pulses toward the bridge
  input  wire logic [8:0] ev_req_i,
  output var  logic [8:0] ev_o
);
  // Registered, so a pulse never overlaps the request edge
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      ev_o <= 9'h000;
    else
      ev_o <= ev_req_i;
  end
endmodule
`default_nettype wire

// ### bwds_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bwds_regs_monitor (
  // Clock, reset and configuration port
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic        cfg_rd_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_rvalid_o,
  // Events and decode
  input wire logic        serr_seen_i,
  input wire logic        addr_attr_fault_target_i,
  input wire logic [63:0] mem_addr_i,
  input wire logic        mem_forward_o,
  input wire logic        prefetch_forward_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire rd1c = cfg_rd_i && (cfg_addr_i[7:2] == 6'h07);
  wire rd20 = cfg_rd_i && (cfg_addr_i[7:2] == 6'h08);
  wire rd24 = cfg_rd_i && (cfg_addr_i[7:2] == 6'h09);
  wire hi_zero = (mem_addr_i[63:32] == 32'h0);
  rd_answer_a: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("read not answered");
  rd_quiet_a: assert property (!cfg_rd_i |=> !cfg_rvalid_o)
    else $error("read answer without request");
  sts_fixed_a: assert property (rd1c |=>
    cfg_rdata_o[26:25] == 2'h1 && cfg_rdata_o[23:16] == 8'hA0)
    else $error("fixed status bits wrong");
  io_kind_a: assert property (rd1c |=> cfg_rdata_o[11:8] == 4'h1)
    else $error("io addressing kind wrong");
  pf_kind_a: assert property (rd24 |=>
    cfg_rdata_o[3:0] == 4'h1 && cfg_rdata_o[19:16] == 4'h1)
    else $error("prefetch indicator wrong");
  mem_low_a: assert property (rd20 |=>
    cfg_rdata_o[3:0] == 4'h0 && cfg_rdata_o[19:16] == 4'h0)
    else $error("memory low nibble not zero");
  serr_flag_a: assert property (rd1c && $past(serr_seen_i) |=>
    cfg_rdata_o[30])
    else $error("system fault flag missing");
  parity_flag_a: assert property (
    rd1c && $past(addr_attr_fault_target_i) |=> cfg_rdata_o[31])
    else $error("parity fault flag missing");
  mem_upper_a: assert property (mem_forward_o |-> $past(hi_zero))
    else $error("memory forward above 4G");
  cover property (rd1c ##1 cfg_rdata_o[31]);
  cover property (mem_forward_o);
  cover property (prefetch_forward_o);
endmodule
bind bwds_regs bwds_regs_monitor u_bwds_regs_monitor (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cfg_addr_i(cfg_addr_i),
  .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o),
  .cfg_rvalid_o(cfg_rvalid_o), .serr_seen_i(serr_seen_i),
  .addr_attr_fault_target_i(addr_attr_fault_target_i),
  .mem_addr_i(mem_addr_i), .mem_forward_o(mem_forward_o),
  .prefetch_forward_o(prefetch_forward_o));
`default_nettype wire

// ### bwds_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bwds_regs_tb;
  logic        clk, rst, wr, rds, rvalid, pe, bm;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic [8:0]  ev, evp;
  logic [31:0] wdata, rdata, io_a, d;
  logic [63:0] mem_a;
  logic [2:0]  fwd;
  int          error_cnt, checks;
  localparam int POS [9] = '{15, 15, 15, 14, 13, 12, 11, 8, 8};
  localparam logic [7:0] AD [5] = '{8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
  localparam logic [31:0] RV [5] = '{32'h02A00121, 32'h0, 32'h00010001,
    32'h0, 32'h0};
  localparam logic [31:0] WV [5] = '{32'h02A0F121, 32'hFFF0FFF0,
    32'hFFF1FFF1, 32'hFFFFFFFF, 32'h0};
  localparam logic [31:0] IOA [8] = '{32'h00011FFF, 32'h00012000,
    32'h00015FFF, 32'h00016000, 32'h00015FFF, 32'h0, 32'h0, 32'h0};
  localparam logic [63:0] MA [8] = '{64'h145800000, 64'h145600000,
    64'h12300000, 64'h124FFFFF, 64'h12500000, 64'h1457FFFFF,
    64'h1455FFFFF, 64'h112300000};
  localparam logic [2:0] FX [8] = '{3'h0, 3'h5, 3'h6, 3'h2, 3'h4, 3'h1,
    3'h0, 3'h0};

  bwds_pci_model u_bwds_pci_model (.ref_clk_i(clk), .sys_rst_i(rst),
    .ev_req_i(ev), .ev_o(evp));
  bwds_regs u_bwds_regs (.ref_clk_i(clk), .sys_rst_i(rst),
    .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wr_i(wr), .cfg_wdata_i(wdata),
    .cfg_rd_i(rds), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
    .io_bottom_field_i(4'h2), .io_bottom_upper_i(16'h0001),
    .io_top_upper_i(16'h0001), .prefetch_top_high_i(32'h1),
    .parity_response_enable_i(pe), .addr_attr_fault_target_i(evp[0]),
    .write_data_fault_target_i(evp[1]), .read_data_fault_master_i(evp[2]),
    .serr_seen_i(evp[3]), .master_termination_i(evp[4]),
    .target_termination_recv_i(evp[5]), .target_termination_sig_i(evp[6]),
    .bus_master_i(bm), .perr_driven_read_i(evp[7]),
    .perr_seen_write_i(evp[8]), .io_addr_i(io_a), .mem_addr_i(mem_a),
    .io_forward_o(fwd[2]), .mem_forward_o(fwd[1]),
    .prefetch_forward_o(fwd[0]));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic complete_run;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrt(input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; be <= b; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    int n;
    @(posedge clk);
    rds <= 1'b1; addr <= a;
    @(posedge clk);
    rds <= 1'b0;
    #1;
    for (n = 0; rvalid !== 1'b1 && n < 4; n++)
      @(posedge clk) #1;
    q = rdata;
    if (n == 4)
    begin
      error_cnt++;
      complete_run();
    end
  endtask

  // Parity enable and bus master go with the request, so they settle first
  task automatic pulse(input logic [8:0] m, input logic p, input logic b);
    @(posedge clk);
    ev <= m; pe <= p; bm <= b;
    @(posedge clk);
    ev <= 9'h000;
  endtask

  task automatic t_reset_values;
    for (int i = 0; i < 5; i++)
    begin
      rd(AD[i], d);
      chk(d, RV[i]);
    end
  endtask

  task automatic t_access;
    for (int i = 0; i < 5; i++)
      wrt(AD[i], 4'hF, 32'hFFFFFFFF);
    for (int i = 0; i < 5; i++)
    begin
      rd(AD[i], d);
      chk(d, WV[i]);
    end
  endtask

  task automatic t_status;
    for (int i = 0; i < 9; i++)
    begin
      pulse(9'h001 << i, 1'b1, 1'b1);
      rd(8'h1C, d);
      chk(d[31:16], 16'h02A0 | (16'h1 << POS[i]));
      wrt(8'h1C, 4'hC, 32'h0);
      rd(8'h1C, d);
      chk(d[31:16], 16'h02A0 | (16'h1 << POS[i]));
      wrt(8'h1C, 4'hC, 32'h1 << (POS[i] + 16));
      rd(8'h1C, d);
      chk(d[31:16], 16'h02A0);
    end
    pulse(9'h080, 1'b0, 1'b1);
    rd(8'h1C, d);
    chk(d[31:16], 16'h02A0);
    pulse(9'h001, 1'b0, 1'b1);
    rd(8'h1C, d);
    chk(d[31:16], 16'h82A0);
    pulse(9'h100, 1'b1, 1'b0);
    rd(8'h1C, d);
    chk(d[31:16], 16'h82A0);
    // System fault pulse meets a clear of the same flag in one cycle
    @(posedge clk);
    ev <= 9'h008;
    @(posedge clk);
    ev <= 9'h000;
    wr <= 1'b1; addr <= 8'h1C; be <= 4'hC; wdata <= 32'h40000000;
    @(posedge clk);
    wr <= 1'b0;
    rd(8'h1C, d);
    chk(d[31:16], 16'hC2A0);
  endtask

  // Windows: io 1_2000..1_5FFF, mem 1230_0000..124F_FFFF,
  // prefetch 1_4560_0000..1_457F_FFFF
  task automatic t_decode;
    wrt(8'h1C, 4'h2, 32'h00005100);
    wrt(8'h20, 4'hF, 32'h12401230);
    wrt(8'h24, 4'hF, 32'h45704560);
    wrt(8'h28, 4'hF, 32'h00000001);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      io_a <= IOA[i]; mem_a <= MA[i];
      @(posedge clk) #1;
      chk({29'h0, fwd}, {29'h0, FX[i]});
    end
  endtask

  initial
  begin
    error_cnt = 0; checks = 0;
    rst = 1'b1; wr = 1'b0; rds = 1'b0; pe = 1'b0; bm = 1'b0;
    addr = 8'h00; be = 4'h0; ev = 9'h000; wdata = 32'h0;
    io_a = 32'h0; mem_a = 64'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_access();
    t_status();
    t_decode();
    complete_run();
  end
endmodule
`default_nettype wire
